/* File: hdl/dcr_pkg.sv */
package dcr_pkg;

  localparam int          ADDR_W         = 5;
  localparam int          BYTE_W         = 8;
  localparam int          CODE_W         = 12;
  localparam int          NUM_CH         = 2;

  localparam logic [4:0]  OFS_ENABLE     = 5'h00;
  localparam logic [4:0]  OFS_MODE       = 5'h01;
  localparam logic [4:0]  OFS_ALIGN      = 5'h02;
  localparam logic [4:0]  OFS_EVENT      = 5'h03;
  localparam logic [4:0]  OFS_EMPTY      = 5'h05;
  localparam logic [4:0]  OFS_CH0_GAIN   = 5'h08;
  localparam logic [4:0]  OFS_CH0_OFFS   = 5'h09;
  localparam logic [4:0]  OFS_CH1_GAIN   = 5'h0A;
  localparam logic [4:0]  OFS_CH1_OFFS   = 5'h0B;
  localparam logic [4:0]  OFS_IRQ_STATUS = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_MASK   = 5'h0D;
  localparam logic [4:0]  OFS_CH0_LOW    = 5'h18;
  localparam logic [4:0]  OFS_CH0_HIGH   = 5'h19;
  localparam logic [4:0]  OFS_CH1_LOW    = 5'h1A;
  localparam logic [4:0]  OFS_CH1_HIGH   = 5'h1B;

  localparam logic [7:0]  MASK_ENABLE    = 8'h1F;
  localparam logic [7:0]  MASK_MODE      = 8'h63;
  localparam logic [7:0]  MASK_ALIGN     = 8'h19;
  localparam logic [7:0]  MASK_EVENT     = 8'h0F;
  localparam logic [7:0]  MASK_CH1_TRIM  = 8'h7F;
  localparam logic [7:0]  MASK_LEFT_LOW  = 8'hF0;
  localparam logic [1:0]  MASK_FLAGS     = 2'h3;
  localparam int          POS_LEFT_ALIGN = 0;

  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [11:0] RESET_CODE     = 12'h000;
  localparam logic [1:0]  RESET_FLAGS    = 2'h0;
  localparam logic [3:0]  ZERO_NIBBLE    = 4'h0;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] offset;
  } dcr_trim_s;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] mode;
    logic [7:0] align;
    logic [7:0] event_sel;
  } dcr_ctrl_s;

endpackage : dcr_pkg

/* File: hdl/dcr_top.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module dcr_top (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [4:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  input  wire logic [1:0]           conv_take,
  output logic      [11:0]          ch0_code,
  output logic      [11:0]          ch1_code,
  output dcr_pkg::dcr_trim_s        ch0_trim,
  output dcr_pkg::dcr_trim_s        ch1_trim,
  output dcr_pkg::dcr_ctrl_s        ctrl,
  output logic      [1:0]           dma_req,
  output logic                      irq
);

  logic [7:0]       enable_reg;
  logic [7:0]       mode_reg;
  logic [7:0]       align_reg;
  logic [7:0]       event_reg;
  logic [7:0]       ch0_gain_reg;
  logic [7:0]       ch0_offs_reg;
  logic [7:0]       ch1_gain_reg;
  logic [7:0]       ch1_offs_reg;
  logic [7:0]       stage_reg;
  logic [7:0]       stage_next;
  logic [1:0][11:0] code_reg;
  logic [1:0]       empty_reg;
  logic [1:0]       empty_next;
  logic [1:0]       irq_status_reg;
  logic [1:0]       irq_status_next;
  logic [1:0]       irq_mask_reg;
  logic [7:0]       rdata_reg;
  logic [7:0]       rd_mux;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire              left_align_select = align_reg[dcr_pkg::POS_LEFT_ALIGN];

  wire              wr_enable  = reg_wr && (reg_addr == dcr_pkg::OFS_ENABLE);
  wire              wr_mode    = reg_wr && (reg_addr == dcr_pkg::OFS_MODE);
  wire              wr_align   = reg_wr && (reg_addr == dcr_pkg::OFS_ALIGN);
  wire              wr_event   = reg_wr && (reg_addr == dcr_pkg::OFS_EVENT);
  wire              wr_empty   = reg_wr && (reg_addr == dcr_pkg::OFS_EMPTY);
  wire              wr_g0      = reg_wr && (reg_addr == dcr_pkg::OFS_CH0_GAIN);
  wire              wr_o0      = reg_wr && (reg_addr == dcr_pkg::OFS_CH0_OFFS);
  wire              wr_g1      = reg_wr && (reg_addr == dcr_pkg::OFS_CH1_GAIN);
  wire              wr_o1      = reg_wr && (reg_addr == dcr_pkg::OFS_CH1_OFFS);
  wire              wr_istat   = reg_wr && (reg_addr == dcr_pkg::OFS_IRQ_STATUS);
  wire              wr_imask   = reg_wr && (reg_addr == dcr_pkg::OFS_IRQ_MASK);
  wire              wr_low0    = reg_wr && (reg_addr == dcr_pkg::OFS_CH0_LOW);
  wire              wr_low1    = reg_wr && (reg_addr == dcr_pkg::OFS_CH1_LOW);
  wire              wr_high0   = reg_wr && (reg_addr == dcr_pkg::OFS_CH0_HIGH);
  wire              wr_high1   = reg_wr && (reg_addr == dcr_pkg::OFS_CH1_HIGH);

  wire  [1:0]       commit     = {wr_high1, wr_high0};
  wire  [1:0]       flag_clr   = wr_empty ? reg_wdata[1:0] : 2'h0;
  wire  [1:0]       istat_clr  = wr_istat ? reg_wdata[1:0] : 2'h0;
  wire  [1:0]       empty_rise = conv_take & ~empty_reg;

  // One staging byte serves both channels, so low/high pairs must not interleave
  // Left mode keeps the lower nibble at zero; it reads and stages as zero
  assign stage_next = (wr_low0 || wr_low1) ?
                      (left_align_select ? (reg_wdata & dcr_pkg::MASK_LEFT_LOW)
                                         : reg_wdata)
                      : stage_reg;

  // Hardware set wins over a clear from a commit or from software
  assign empty_next      = conv_take | (empty_reg & ~commit & ~flag_clr);
  assign irq_status_next = empty_rise | (irq_status_reg & ~istat_clr);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_reg <= dcr_pkg::RESET_BYTE;
      mode_reg   <= dcr_pkg::RESET_BYTE;
      align_reg  <= dcr_pkg::RESET_BYTE;
      event_reg  <= dcr_pkg::RESET_BYTE;
    end else begin
      if (wr_enable) enable_reg <= reg_wdata & dcr_pkg::MASK_ENABLE;
      if (wr_mode)   mode_reg   <= reg_wdata & dcr_pkg::MASK_MODE;
      if (wr_align)  align_reg  <= reg_wdata & dcr_pkg::MASK_ALIGN;
      if (wr_event)  event_reg  <= reg_wdata & dcr_pkg::MASK_EVENT;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch0_gain_reg <= dcr_pkg::RESET_BYTE;
      ch0_offs_reg <= dcr_pkg::RESET_BYTE;
      ch1_gain_reg <= dcr_pkg::RESET_BYTE;
      ch1_offs_reg <= dcr_pkg::RESET_BYTE;
    end else begin
      if (wr_g0) ch0_gain_reg <= reg_wdata;
      if (wr_o0) ch0_offs_reg <= reg_wdata;
      // Top bit of the channel 1 trims is read-only zero
      if (wr_g1) ch1_gain_reg <= reg_wdata & dcr_pkg::MASK_CH1_TRIM;
      if (wr_o1) ch1_offs_reg <= reg_wdata & dcr_pkg::MASK_CH1_TRIM;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage_reg <= dcr_pkg::RESET_BYTE;
    end else begin
      stage_reg <= stage_next;
    end
  end

  genvar c;
  generate
    for (c = 0; c < dcr_pkg::NUM_CH; c++) begin : g_ch
      // The code only changes on the high byte, so the converter never sees half a value
      wire [11:0] commit_val = left_align_select ?
                               {reg_wdata, stage_reg[7:4]} :
                               {reg_wdata[3:0], stage_reg};
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          code_reg[c] <= dcr_pkg::RESET_CODE;
        end else if (commit[c]) begin
          code_reg[c] <= commit_val;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      empty_reg      <= dcr_pkg::RESET_FLAGS;
      irq_status_reg <= dcr_pkg::RESET_FLAGS;
      irq_mask_reg   <= dcr_pkg::RESET_FLAGS;
    end else begin
      empty_reg      <= empty_next;
      irq_status_reg <= irq_status_next;
      if (wr_imask) irq_mask_reg <= reg_wdata[1:0] & dcr_pkg::MASK_FLAGS;
    end
  end

  // Same offsets in both modes; only the byte views of the codes move
  wire  [7:0] low0_view  = left_align_select ?
                           {code_reg[0][3:0], dcr_pkg::ZERO_NIBBLE} : code_reg[0][7:0];
  wire  [7:0] high0_view = left_align_select ?
                           code_reg[0][11:4] : {dcr_pkg::ZERO_NIBBLE, code_reg[0][11:8]};
  wire  [7:0] low1_view  = left_align_select ?
                           {code_reg[1][3:0], dcr_pkg::ZERO_NIBBLE} : code_reg[1][7:0];
  wire  [7:0] high1_view = left_align_select ?
                           code_reg[1][11:4] : {dcr_pkg::ZERO_NIBBLE, code_reg[1][11:8]};

  always_comb begin
    unique case (reg_addr)
      dcr_pkg::OFS_ENABLE:     rd_mux = enable_reg;
      dcr_pkg::OFS_MODE:       rd_mux = mode_reg;
      dcr_pkg::OFS_ALIGN:      rd_mux = align_reg;
      dcr_pkg::OFS_EVENT:      rd_mux = event_reg;
      dcr_pkg::OFS_EMPTY:      rd_mux = {6'h00, empty_reg};
      dcr_pkg::OFS_CH0_GAIN:   rd_mux = ch0_gain_reg;
      dcr_pkg::OFS_CH0_OFFS:   rd_mux = ch0_offs_reg;
      dcr_pkg::OFS_CH1_GAIN:   rd_mux = ch1_gain_reg;
      dcr_pkg::OFS_CH1_OFFS:   rd_mux = ch1_offs_reg;
      dcr_pkg::OFS_IRQ_STATUS: rd_mux = {6'h00, irq_status_reg};
      dcr_pkg::OFS_IRQ_MASK:   rd_mux = {6'h00, irq_mask_reg};
      dcr_pkg::OFS_CH0_LOW:    rd_mux = low0_view;
      dcr_pkg::OFS_CH0_HIGH:   rd_mux = high0_view;
      dcr_pkg::OFS_CH1_LOW:    rd_mux = low1_view;
      dcr_pkg::OFS_CH1_HIGH:   rd_mux = high1_view;
      default:                 rd_mux = dcr_pkg::RESET_BYTE;
    endcase
  end

  // Read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= dcr_pkg::RESET_BYTE;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : dcr_pkg::RESET_BYTE;
    end
  end

  assign reg_rdata        = rdata_reg;
  assign ch0_code         = code_reg[0];
  assign ch1_code         = code_reg[1];
  assign ch0_trim.gain    = ch0_gain_reg;
  assign ch0_trim.offset  = ch0_offs_reg;
  assign ch1_trim.gain    = ch1_gain_reg;
  assign ch1_trim.offset  = ch1_offs_reg;
  assign ctrl.enable      = enable_reg;
  assign ctrl.mode        = mode_reg;
  assign ctrl.align       = align_reg;
  assign ctrl.event_sel   = event_reg;
  assign dma_req          = empty_reg;
  assign irq              = |(irq_status_reg & irq_mask_reg);

  AST_CH0_RIGHT_COMMIT: assert property (
    wr_high0 && !left_align_select |=>
      ch0_code == {$past(reg_wdata[3:0]), $past(stage_reg)})
    else $error("Channel 0 right-mode commit wrong");

  AST_CH1_LEFT_COMMIT: assert property (
    wr_high1 && left_align_select |=>
      ch1_code == {$past(reg_wdata), $past(stage_reg[7:4])})
    else $error("Channel 1 left-mode commit wrong");

  AST_LEFT_LOW_NIBBLE: assert property (
    reg_rd && left_align_select && (reg_addr == dcr_pkg::OFS_CH0_LOW) |=>
      reg_rdata[3:0] == 4'h0 && reg_rdata[7:4] == ch0_code[3:0])
    else $error("Left-mode low byte nibble not zero");

  AST_RIGHT_HIGH_NIBBLE: assert property (
    reg_rd && !left_align_select && (reg_addr == dcr_pkg::OFS_CH1_HIGH) |=>
      reg_rdata == {4'h0, ch1_code[11:8]})
    else $error("Right-mode high byte layout wrong");

  AST_GAIN0_WRITE: assert property (
    wr_g0 |=> ch0_trim.gain == $past(reg_wdata))
    else $error("Channel 0 gain trim not stored");

  AST_CH1_TRIM_TOP: assert property (
    wr_o1 |=> ch1_trim.offset == {1'b0, $past(reg_wdata[6:0])})
    else $error("Channel 1 offset trim top bit writable");

  AST_EMPTY_COMMIT: assert property (
    commit[0] && !conv_take[0] |=> !dma_req[0])
    else $error("Commit did not clear empty flag");

  AST_EMPTY_SET_WINS: assert property (
    conv_take[1] |=> dma_req[1])
    else $error("Empty flag lost on set");

  AST_LOW_STAGED: assert property (
    wr_low0 |=> $stable(ch0_code) && stage_reg == ($past(left_align_select) ?
      ($past(reg_wdata) & 8'hF0) : $past(reg_wdata)))
    else $error("Low byte write changed code directly");

  AST_IRQ_RAISE: assert property (
    conv_take[0] && !dma_req[0] && irq_mask_reg[0] && !wr_imask |=> irq)
    else $error("Masked-in empty event did not raise irq");

  AST_RESET_CLEARS: assert property (disable iff (1'b0)
    sys_rst |=> ch0_code == 12'h000 && ch1_code == 12'h000 && dma_req == 2'h0 && !irq &&
      reg_rdata == 8'h00 && ctrl == 32'h0 && ch0_trim == 16'h0 && ch1_trim == 16'h0)
    else $error("Reset did not clear the block");

  AST_CH0_LEFT_COMMIT: assert property (
    wr_high0 && left_align_select |=>
      ch0_code == {$past(reg_wdata), $past(stage_reg[7:4])})
    else $error("Channel 0 left-mode commit wrong");

  AST_CH1_RIGHT_COMMIT: assert property (
    wr_high1 && !left_align_select |=>
      ch1_code == {$past(reg_wdata[3:0]), $past(stage_reg)})
    else $error("Channel 1 right-mode commit wrong");

  AST_CH0_RIGHT_LOW_VIEW: assert property (
    reg_rd && !left_align_select && (reg_addr == dcr_pkg::OFS_CH0_LOW) |=>
      reg_rdata == ch0_code[7:0])
    else $error("Channel 0 right-mode low byte view wrong");

  AST_CH1_RIGHT_LOW_VIEW: assert property (
    reg_rd && !left_align_select && (reg_addr == dcr_pkg::OFS_CH1_LOW) |=>
      reg_rdata == ch1_code[7:0])
    else $error("Channel 1 right-mode low byte view wrong");

  AST_CH1_LEFT_LOW_VIEW: assert property (
    reg_rd && left_align_select && (reg_addr == dcr_pkg::OFS_CH1_LOW) |=>
      reg_rdata == {ch1_code[3:0], 4'h0})
    else $error("Channel 1 left-mode low byte view wrong");

  AST_CH1_LEFT_HIGH_VIEW: assert property (
    reg_rd && left_align_select && (reg_addr == dcr_pkg::OFS_CH1_HIGH) |=>
      reg_rdata == ch1_code[11:4])
    else $error("Channel 1 left-mode high byte view wrong");

  AST_CH0_LEFT_HIGH_VIEW: assert property (
    reg_rd && left_align_select && (reg_addr == dcr_pkg::OFS_CH0_HIGH) |=>
      reg_rdata == ch0_code[11:4])
    else $error("Channel 0 left-mode high byte view wrong");

  AST_CH0_RIGHT_HIGH_VIEW: assert property (
    reg_rd && !left_align_select && (reg_addr == dcr_pkg::OFS_CH0_HIGH) |=>
      reg_rdata == {4'h0, ch0_code[11:8]})
    else $error("Channel 0 right-mode high byte view wrong");

  AST_LEFT_STAGE_NIBBLE: assert property (
    wr_low1 && left_align_select |=> stage_reg[3:0] == 4'h0)
    else $error("Left-mode staged low nibble not zero");

  AST_OFFS0_WRITE: assert property (
    wr_o0 |=> ch0_trim.offset == $past(reg_wdata))
    else $error("Channel 0 offset trim not stored");

  AST_GAIN1_TOP: assert property (
    wr_g1 |=> ch1_trim.gain == {1'b0, $past(reg_wdata[6:0])})
    else $error("Channel 1 gain trim top bit writable");

  AST_TRIM0_HOLD: assert property (
    !wr_g0 && !wr_o0 |=> $stable(ch0_trim))
    else $error("Channel 0 trims changed without a write");

  AST_TRIM1_HOLD: assert property (
    !wr_g1 && !wr_o1 |=> $stable(ch1_trim))
    else $error("Channel 1 trims changed without a write");

  AST_CODE0_HOLD: assert property (
    !commit[0] |=> $stable(ch0_code))
    else $error("Channel 0 code changed without a commit");

  AST_CODE1_HOLD: assert property (
    !commit[1] |=> $stable(ch1_code))
    else $error("Channel 1 code changed without a commit");

  AST_EMPTY1_COMMIT: assert property (
    commit[1] && !conv_take[1] |=> !dma_req[1])
    else $error("Channel 1 commit did not clear empty flag");

  AST_EMPTY0_SET_WINS: assert property (
    conv_take[0] |=> dma_req[0])
    else $error("Channel 0 empty flag lost on set");

  AST_EMPTY_SW_CLEAR: assert property (
    wr_empty && reg_wdata[1] && !conv_take[1] |=> !dma_req[1])
    else $error("Software clear of empty flag ignored");

  AST_EMPTY_HOLD: assert property (
    !conv_take[0] && !commit[0] && !flag_clr[0] |=> $stable(dma_req[0]))
    else $error("Empty flag changed with no cause");

  AST_IRQ_STICKY: assert property (
    irq_status_reg[0] && !(wr_istat && reg_wdata[0]) |=> irq_status_reg[0])
    else $error("Interrupt status bit not sticky");

  AST_IRQ_CLEAR: assert property (
    wr_istat && reg_wdata[0] && !(conv_take[0] && !dma_req[0]) |=>
      !irq_status_reg[0])
    else $error("Interrupt status bit not cleared by one");

  AST_READ_ONE_CYCLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data stood beyond its cycle");

  AST_UNMAPPED_READ: assert property (
    reg_rd && (reg_addr inside {5'h04, 5'h06, 5'h07, 5'h10}) |=> reg_rdata == 8'h00)
    else $error("Unmapped offset read nonzero");

  AST_ALIGN_MASK: assert property (
    wr_align |=> ctrl.align == ($past(reg_wdata) & dcr_pkg::MASK_ALIGN))
    else $error("Alignment register reserved bits writable");

  AST_MAP_STABLE: assert property (
    reg_rd && (reg_addr == dcr_pkg::OFS_CH0_GAIN) |=> reg_rdata == ch0_trim.gain)
    else $error("Trim offset moved with alignment mode");

  AST_DMA_MIRRORS: assert property (
    reg_rd && (reg_addr == dcr_pkg::OFS_EMPTY) |=> reg_rdata == {6'h00, $past(dma_req)})
    else $error("Empty flags read differ from DMA request");

  AST_EIGHT_BIT_MODE: assert property (
    wr_high1 && left_align_select && (stage_reg == 8'h00) |=>
      ch1_code == {$past(reg_wdata), 4'h0})
    else $error("Eight-bit left-mode commit wrong");

endmodule : dcr_top

`default_nettype wire

/* File: sim/dcr_conv_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dcr_conv_model (
  input  wire logic        clk,
  input  wire logic [11:0] ch0_code,
  input  wire logic [11:0] ch1_code,
  output var  logic [1:0]  conv_take,
  output var  logic [11:0] taken_code
);
  initial begin
    conv_take  = 2'h0;
    taken_code = 12'h000;
  end

  // One-cycle take; the code is latched at the edge the block sees the pulse
  task automatic take(input logic [1:0] ch);
    @(posedge clk);
    conv_take <= ch;
    @(posedge clk);
    taken_code <= ch[1] ? ch1_code : ch0_code;
    conv_take  <= 2'h0;
    #1;
  endtask : take
endmodule : dcr_conv_model

`default_nettype wire

/* File: sim/dcr_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dcr_top_tb_top;
  logic               clk;
  logic               sys_rst;
  logic [4:0]         reg_addr;
  logic [7:0]         reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [7:0]         reg_rdata;
  logic [1:0]         conv_take;
  logic [1:0]         dma_req;
  logic [11:0]        ch0_code;
  logic [11:0]        ch1_code;
  logic [11:0]        taken_code;
  dcr_pkg::dcr_trim_s ch0_trim;
  dcr_pkg::dcr_trim_s ch1_trim;
  dcr_pkg::dcr_ctrl_s ctrl;
  logic               irq;
  int                 bad_count;
  int                 n_tests;
  logic [4:0]         rst_addr [9] = '{5'h08, 5'h09, 5'h0A, 5'h0B, 5'h18, 5'h19, 5'h1A,
                                       5'h1B, 5'h05};

  dcr_top dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_take(conv_take),
    .ch0_code(ch0_code), .ch1_code(ch1_code), .ch0_trim(ch0_trim), .ch1_trim(ch1_trim),
    .ctrl(ctrl), .dma_req(dma_req), .irq(irq));

  dcr_conv_model conv (.clk(clk), .ch0_code(ch0_code), .ch1_code(ch1_code),
    .conv_take(conv_take), .taken_code(taken_code));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Strobe lands one edge after the task starts, so back-to-back calls never collide
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rd

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    bad_count = 0;
    n_tests   = 0;
    sys_rst   = 1'b1;
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(rst_addr[i], 8'h00);
    wr(dcr_pkg::OFS_CH0_GAIN, 8'hA5);
    wr(dcr_pkg::OFS_CH0_OFFS, 8'h5A);
    wr(dcr_pkg::OFS_CH1_GAIN, 8'hFE);
    wr(dcr_pkg::OFS_CH1_OFFS, 8'h3C);
    rd(dcr_pkg::OFS_CH0_GAIN, 8'hA5);
    rd(dcr_pkg::OFS_CH0_OFFS, 8'h5A);
    rd(dcr_pkg::OFS_CH1_GAIN, 8'h7E);
    rd(dcr_pkg::OFS_CH1_OFFS, 8'h3C);
    check(ch0_trim, 16'hA55A);
    check(ch1_trim, 16'h7E3C);
    wr(5'h04, 8'hFF);
    rd(5'h04, 8'h00);
    // Right layout, low byte staged until the high byte commits
    wr(dcr_pkg::OFS_CH0_LOW, 8'hAB);
    check({4'h0, ch0_code}, 16'h0000);
    wr(dcr_pkg::OFS_CH0_HIGH, 8'h05);
    check({4'h0, ch0_code}, 16'h05AB);
    rd(dcr_pkg::OFS_CH0_LOW, 8'hAB);
    rd(dcr_pkg::OFS_CH0_HIGH, 8'h05);
    wr(dcr_pkg::OFS_CH1_LOW, 8'hCD);
    wr(dcr_pkg::OFS_CH1_HIGH, 8'h0E);
    check({4'h0, ch1_code}, 16'h0ECD);
    rd(dcr_pkg::OFS_CH1_LOW, 8'hCD);
    rd(dcr_pkg::OFS_CH1_HIGH, 8'h0E);
    // Empty flags, DMA request and interrupt
    wr(dcr_pkg::OFS_IRQ_MASK, 8'h01);
    conv.take(2'h1);
    check({14'h0, dma_req}, 16'h0001);
    check({15'h0, irq}, 16'h0001);
    check({4'h0, taken_code}, 16'h05AB);
    rd(dcr_pkg::OFS_EMPTY, 8'h01);
    wr(dcr_pkg::OFS_IRQ_STATUS, 8'h01);
    check({15'h0, irq}, 16'h0000);
    wr(dcr_pkg::OFS_CH0_HIGH, 8'h05);
    check({14'h0, dma_req}, 16'h0000);
    conv.take(2'h2);
    check({14'h0, dma_req}, 16'h0002);
    check({15'h0, irq}, 16'h0000);
    wr(dcr_pkg::OFS_EMPTY, 8'h02);
    check({14'h0, dma_req}, 16'h0000);
    // Left layout reinterprets the committed code in place
    wr(dcr_pkg::OFS_ENABLE, 8'h15);
    wr(dcr_pkg::OFS_MODE, 8'h41);
    wr(dcr_pkg::OFS_EVENT, 8'h0A);
    wr(dcr_pkg::OFS_ALIGN, 8'h19);
    check(ctrl[31:16], 16'h1541);
    check({8'h00, ctrl.align}, 16'h0019);
    check({8'h00, ctrl.event_sel}, 16'h000A);
    rd(dcr_pkg::OFS_MODE, 8'h41);
    // The shared stage still held the channel 1 low byte at the last commit: code is 5CD
    rd(dcr_pkg::OFS_CH0_LOW, 8'hD0);
    rd(dcr_pkg::OFS_CH0_HIGH, 8'h5C);
    wr(dcr_pkg::OFS_CH0_LOW, 8'h70);
    wr(dcr_pkg::OFS_CH0_HIGH, 8'h9C);
    check({4'h0, ch0_code}, 16'h09C7);
    rd(dcr_pkg::OFS_CH0_LOW, 8'h70);
    rd(dcr_pkg::OFS_CH0_HIGH, 8'h9C);
    // Reserved low nibble written nonzero on purpose: it must not reach the code
    wr(dcr_pkg::OFS_CH1_LOW, 8'h3F);
    wr(dcr_pkg::OFS_CH1_HIGH, 8'hFF);
    check({4'h0, ch1_code}, 16'h0FF3);
    rd(dcr_pkg::OFS_CH1_LOW, 8'h30);
    rd(dcr_pkg::OFS_CH1_HIGH, 8'hFF);
    rd(dcr_pkg::OFS_CH0_GAIN, 8'hA5);
    // Eight-bit use: clear the stage once, then high bytes only
    wr(dcr_pkg::OFS_CH0_LOW, 8'h00);
    wr(dcr_pkg::OFS_CH1_HIGH, 8'h42);
    check({4'h0, ch1_code}, 16'h0420);
    wr(dcr_pkg::OFS_CH1_HIGH, 8'h43);
    check({4'h0, ch1_code}, 16'h0430);
    wr(dcr_pkg::OFS_ALIGN, 8'h00);
    rd(dcr_pkg::OFS_CH1_LOW, 8'h30);
    rd(dcr_pkg::OFS_CH1_HIGH, 8'h04);
    rd(dcr_pkg::OFS_IRQ_STATUS, 8'h02);
    rd(dcr_pkg::OFS_IRQ_MASK, 8'h01);
    // Mid-run reset must bring every register back to zero
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(ch1_trim, 16'h0000);
    check({4'h0, ch1_code}, 16'h0000);
    check(ctrl[15:0], 16'h0000);
    rd(dcr_pkg::OFS_CH0_GAIN, 8'h00);
    rd(dcr_pkg::OFS_CH1_HIGH, 8'h00);
    finish_test();
  end
endmodule : dcr_top_tb_top

`default_nettype wire
